// ===== rtl/dsrs_pkg.sv
/*
 dsrs_pkg: timing counts, byte formats and state types for the
 serial register host.
 assumes a 40 MHz system clock; no other file state is shared.
*/
package dsrs_pkg;
   localparam int         CLK_PERIOD_NS = 25;
   // quarter of a 400 kHz bit, fast-mode rate
   localparam int         I2C_QTR_NS    = 625;
   localparam int         I2C_QTR_CYC   =
      (I2C_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         SPI_HALF_NS   = 100;
   localparam int         SPI_HALF_CYC  =
      (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] I2C_ADDR_HI   = 6'h0c;
   localparam logic       RW_READ       = 1'b1;
   localparam logic       RW_WRITE      = 1'b0;
   localparam logic [3:0] LAST_BIT      = 4'h7;
   localparam logic [3:0] ACK_BIT       = 4'h8;
   localparam logic [7:0] IDLE_BYTE     = 8'hff;
   localparam int         SY_SDA        = 0;
   localparam int         SY_SCL        = 1;
   localparam int         SY_SDO        = 2;
   localparam int         SY_SDI        = 3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_I_START,
      ST_I_BYTE,
      ST_I_STOP,
      ST_S_LEAD,
      ST_S_BIT,
      ST_S_TAIL
   } dsrs_state_type;

   typedef enum logic [2:0] {
      SQ_ADDR_W,
      SQ_SUB,
      SQ_WDATA,
      SQ_ADDR_R,
      SQ_RDATA
   } dsrs_seq_type;
endpackage : dsrs_pkg

// ===== rtl/dsrs_host.sv
/*
 dsrs_host: master for a register slave reached over a two-wire
 link or a four/three-wire serial port link, with burst transfers.
 assumes external pull-ups on scl/sda and on sdi while released;
 the user starts a command only while busy_o is low.
*/
// Operation
// - receiver pulls data low through the ninth clock high phase
// - transmitter releases data during the acknowledge pulse
// - sub-address byte: low seven bits index, top bit auto-increment
// - read: address+write, sub-address, repeated start, address+read
// - master acknowledges wanted bytes, not the last, then stop
// - write: address+write, sub-address, data bytes, then stop
// - bytes are eight bits, most significant first, any count; cmd_len_i gives 1 to 255, 0 taken as 1
// - a busy receiver may hold the clock low to stall
// - unacknowledged address leaves data high; master aborts
// - start falls, stop rises, data while clock high; stop ends all
// - chip select low for whole command, clock high while deselected
// - data changes on falling clock, sampled on rising clock
// - one register takes sixteen pulses, each further one eight more
// - chip select high gives the two-wire link, low the serial port
module dsrs_host #(
   parameter int QTR_CYC  = dsrs_pkg::I2C_QTR_CYC,
   parameter int HALF_CYC = dsrs_pkg::SPI_HALF_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       cmd_start_i,
   input  wire logic       cmd_read_i,
   input  wire logic       cmd_spi_i,
   input  wire logic       three_wire_select_i,
   input  wire logic       auto_increment_bit_i,
   input  wire logic       addr_lsb_select_pin_i,
   input  wire logic [6:0] cmd_reg_i,
   input  wire logic [7:0] cmd_len_i,
   input  wire logic [7:0] write_data_bits_i,
   output logic            wdata_take_o,
   output logic [7:0]      rdata_o,
   output logic            rdata_valid_o,
   output logic            busy_o,
   output logic            done_o,
   output logic            nack_o,
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   output logic            cs_n_o,
   output logic            serial_port_clock_o,
   input  wire logic       sdi_i,
   output logic            sdi_o,
   output logic            sdi_oe_o,
   input  wire logic       sdo_i
);
   import dsrs_pkg::*;

   localparam logic [7:0] QTR_LD  = 8'(QTR_CYC - 1);
   localparam logic [7:0] HALF_LD = 8'(HALF_CYC - 1);

   typedef struct packed {
      dsrs_state_type st;
      dsrs_seq_type   sq;
      logic [1:0]     ph;
      logic [7:0]     cnt;
      logic [3:0]     bitn;
      logic [7:0]     left;
      logic [7:0]     nlen;
      logic [7:0]     sh;
      logic [6:0]     reg_a;
      logic           rd;
      logic           spi;
      logic           tw;
      logic           inc;
      logic           lsb;
      logic           lo;
      logic           scl_oe;
      logic           sda_oe;
      logic           cs_n;
      logic           serial_port_clock;
      logic           mosi;
      logic           mosi_oe;
      logic [7:0]     rdata;
      logic           rvalid;
      logic           wtake;
      logic           busy;
      logic           done;
      logic           nack;
      logic [3:0]     sy0;
      logic [3:0]     sy1;
      logic [3:0]     sy2;
      logic [3:0]     flt;
   } dsrs_host_state_type;

   dsrs_host_state_type q;
   dsrs_host_state_type d;
   logic                stall;
   logic                tick;
   logic                data_byte;
   logic                data_end;
   logic                ack_end;

   // clock held low by the slave freezes the high phase
   assign stall     = (q.st == ST_I_BYTE) && (q.ph == 2'h2) &&
                      !q.flt[SY_SCL];
   assign tick      = (q.cnt == 8'h00) && !stall && (q.st != ST_IDLE);
   assign data_byte = (q.sq == SQ_WDATA) || (q.sq == SQ_RDATA);
   assign data_end  = data_byte && (q.left == 8'h01);
   assign ack_end   = tick && (q.st == ST_I_BYTE) && (q.ph == 2'h3) &&
                      (q.bitn == ACK_BIT);

   function automatic logic [7:0] byte_for(input dsrs_seq_type s);
      case (s)
         SQ_ADDR_W: byte_for = {I2C_ADDR_HI, q.lsb, RW_WRITE};
         SQ_SUB:    byte_for = {q.inc, q.reg_a};
         SQ_WDATA:  byte_for = write_data_bits_i;
         SQ_ADDR_R: byte_for = {I2C_ADDR_HI, q.lsb, RW_READ};
         default:   byte_for = IDLE_BYTE;
      endcase
   endfunction : byte_for

   always_comb
   begin
      logic smp;
      logic load;
      smp      = 1'b0;
      load     = 1'b0;
      d        = q;
      d.rvalid = 1'b0;
      d.wtake  = 1'b0;
      d.done   = 1'b0;
      // three-stage input sync, change taken when stages 2 and 3 agree
      d.sy0    = {sdi_i, sdo_i, scl_i, sda_i};
      d.sy1    = q.sy0;
      d.sy2    = q.sy1;
      d.flt    = ((q.sy1 ~^ q.sy2) & q.sy2) | ((q.sy1 ^ q.sy2) & q.flt);
      if (tick)
         d.cnt = q.spi ? HALF_LD : QTR_LD;
      else if (!stall && (q.st != ST_IDLE))
         d.cnt = q.cnt - 8'h01;
      case (q.st)
         ST_IDLE:
            if (cmd_start_i)
            begin
               d.busy  = 1'b1;
               d.nack  = 1'b0;
               d.rd    = cmd_read_i;
               d.spi   = cmd_spi_i;
               d.tw    = three_wire_select_i;
               d.inc   = auto_increment_bit_i;
               d.lsb   = addr_lsb_select_pin_i;
               d.reg_a = cmd_reg_i;
               d.nlen  = (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
               d.left  = d.nlen;
               d.ph    = 2'h0;
               d.sq    = SQ_ADDR_W;
               d.cnt   = cmd_spi_i ? HALF_LD : QTR_LD;
               if (cmd_spi_i)
               begin
                  d.st      = ST_S_LEAD;
                  d.cs_n    = 1'b0;
                  d.mosi_oe = 1'b1;
                  d.sq      = SQ_SUB;
                  d.sh      = {cmd_read_i, auto_increment_bit_i,
                               cmd_reg_i[5:0]};
               end
               else
               begin
                  d.st     = ST_I_START;
                  d.sda_oe = 1'b0;
               end
            end
         ST_I_START:
            if (tick)
            begin
               d.ph = q.ph + 2'h1;
               case (q.ph)
                  2'h0: d.scl_oe = 1'b0;
                  2'h1: d.sda_oe = 1'b1;
                  2'h2: d.scl_oe = 1'b1;
                  default:
                  begin
                     d.st = ST_I_BYTE;
                     load = 1'b1;
                  end
               endcase
            end
         ST_I_BYTE:
            if (tick)
            begin
               d.ph = q.ph + 2'h1;
               // data moves a quarter after the clock falls, never with it
               if (q.ph == 2'h0)
               begin
                  if (q.bitn == ACK_BIT)
                     d.sda_oe = (q.sq == SQ_RDATA) &&
                                (q.left != 8'h01);
                  else
                     d.sda_oe = ~q.sh[7];
               end
               if (q.ph == 2'h1)
                  d.scl_oe = 1'b0;
               if (q.ph == 2'h3)
               begin
                  smp      = q.flt[SY_SDA];
                  d.scl_oe = 1'b1;
                  d.bitn   = q.bitn + 4'h1;
                  if (q.bitn != ACK_BIT)
                     d.sh = {q.sh[6:0], smp};
                  else if (smp && (q.sq != SQ_RDATA))
                  begin
                     d.nack = 1'b1;
                     d.st   = ST_I_STOP;
                  end
                  else
                  begin
                     if (q.sq == SQ_RDATA)
                     begin
                        d.rdata  = q.sh;
                        d.rvalid = 1'b1;
                     end
                     if (data_byte)
                        d.left = q.left - 8'h01;
                     if (q.sq == SQ_ADDR_W)
                        d.sq = SQ_SUB;
                     else if (q.sq == SQ_ADDR_R)
                        d.sq = SQ_RDATA;
                     else if (q.sq == SQ_SUB)
                        d.sq = q.rd ? SQ_ADDR_R : SQ_WDATA;
                     if ((q.sq == SQ_SUB) && q.rd)
                     begin
                        d.st     = ST_I_START;
                        d.sda_oe = 1'b0;
                     end
                     else if (data_end)
                        d.st = ST_I_STOP;
                     else
                        load = 1'b1;
                  end
               end
            end
         ST_I_STOP:
            if (tick)
            begin
               d.ph = q.ph + 2'h1;
               case (q.ph)
                  2'h0: d.sda_oe = 1'b1;
                  2'h1: d.scl_oe = 1'b0;
                  2'h2: d.sda_oe = 1'b0;
                  default:
                  begin
                     d.st   = ST_IDLE;
                     d.busy = 1'b0;
                     d.done = 1'b1;
                  end
               endcase
            end
         ST_S_LEAD:
            if (tick)
            begin
               d.st   = ST_S_BIT;
               d.serial_port_clock  = 1'b0;
               d.mosi = q.sh[7];
               d.bitn = 4'h0;
               d.ph   = 2'h0;
            end
         ST_S_BIT:
            if (tick && (q.ph == 2'h0))
            begin
               d.serial_port_clock = 1'b1;
               d.ph  = 2'h1;
            end
            else if (tick)
            begin
               smp  = q.tw ? q.flt[SY_SDI] : q.flt[SY_SDO];
               d.sh = {q.sh[6:0], smp};
               if (q.bitn != LAST_BIT)
               begin
                  d.bitn = q.bitn + 4'h1;
                  d.serial_port_clock  = 1'b0;
                  d.mosi = q.sh[6];
                  d.ph   = 2'h0;
               end
               else
               begin
                  if (q.sq == SQ_RDATA)
                  begin
                     d.rdata  = {q.sh[6:0], smp};
                     d.rvalid = 1'b1;
                  end
                  if (data_byte)
                     d.left = q.left - 8'h01;
                  if (q.sq == SQ_SUB)
                  begin
                     d.sq      = q.rd ? SQ_RDATA : SQ_WDATA;
                     d.mosi_oe = !(q.rd && q.tw);
                  end
                  if (data_end)
                     d.st = ST_S_TAIL;
                  else
                     load = 1'b1;
               end
            end
         ST_S_TAIL:
            if (tick)
            begin
               d.cs_n    = 1'b1;
               d.mosi_oe = 1'b0;
               d.st      = ST_IDLE;
               d.busy    = 1'b0;
               d.done    = 1'b1;
            end
         default:
            d.st = ST_IDLE;
      endcase
      if (load)
      begin
         d.bitn  = 4'h0;
         d.sh    = byte_for(d.sq);
         d.wtake = (d.sq == SQ_WDATA);
         if (q.spi)
         begin
            d.serial_port_clock  = 1'b0;
            d.mosi = d.sh[7];
            d.ph   = 2'h0;
         end
      end
   end

   always_ff @(posedge clk_i)
      if (srst_i)
      begin
         q      <= '0;
         q.cs_n <= 1'b1;
         q.serial_port_clock  <= 1'b1;
         q.sy0  <= 4'hf;
         q.sy1  <= 4'hf;
         q.sy2  <= 4'hf;
         q.flt  <= 4'hf;
      end
      else
         q <= d;

   assign scl_o               = q.lo;
   assign scl_oe_o            = q.scl_oe;
   assign sda_o               = q.lo;
   assign sda_oe_o            = q.sda_oe;
   assign cs_n_o              = q.cs_n;
   assign serial_port_clock_o = q.serial_port_clock;
   assign sdi_o               = q.mosi;
   assign sdi_oe_o            = q.mosi_oe;
   assign wdata_take_o        = q.wtake;
   assign rdata_o             = q.rdata;
   assign rdata_valid_o       = q.rvalid;
   assign busy_o              = q.busy;
   assign done_o              = q.done;
   assign nack_o              = q.nack;

   // rising clock edges seen in one chip-select frame
   logic [11:0] rises_q;
   always_ff @(posedge clk_i)
      if (srst_i || q.cs_n)
         rises_q <= 12'h000;
      else if (!q.serial_port_clock && d.serial_port_clock)
         rises_q <= rises_q + 12'h001;

   default clocking dsrs_cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   property p_cs_clk_high;
      q.cs_n |-> q.serial_port_clock;
   endproperty
   a_cs_clk_high: assert property (p_cs_clk_high)
      else $error("serial clock low while deselected");
   property p_two_wire_cs;
      (q.st == ST_I_BYTE) |-> q.cs_n;
   endproperty
   a_two_wire_cs: assert property (p_two_wire_cs)
      else $error("chip select low during two-wire transfer");
   property p_start;
      $rose(q.sda_oe) && !q.scl_oe && !$past(q.scl_oe)
         |-> q.st == ST_I_START;
   endproperty
   a_start: assert property (p_start)
      else $error("data fell with clock high outside start");
   property p_stop;
      $fell(q.sda_oe) && !q.scl_oe && !$past(q.scl_oe)
         |-> q.st == ST_I_STOP;
   endproperty
   a_stop: assert property (p_stop)
      else $error("data rose with clock high outside stop");
   property p_tx_release;
      (q.st == ST_I_BYTE) && (q.bitn == ACK_BIT) && !q.scl_oe &&
         (q.sq != SQ_RDATA) |-> !q.sda_oe;
   endproperty
   a_tx_release: assert property (p_tx_release)
      else $error("data held during slave acknowledge");
   property p_master_ack;
      (q.st == ST_I_BYTE) && (q.bitn == ACK_BIT) && !q.scl_oe &&
         (q.sq == SQ_RDATA) |-> q.sda_oe == (q.left != 8'h01);
   endproperty
   a_master_ack: assert property (p_master_ack)
      else $error("wrong master acknowledge level");
   property p_stretch;
      stall |=> (q.ph == 2'h2) && !q.scl_oe;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("held clock not waited for");
   property p_nack_abort;
      ack_end && q.flt[SY_SDA] && (q.sq != SQ_RDATA)
         |=> (q.st == ST_I_STOP) && q.nack && q.scl_oe;
   endproperty
   a_nack_abort: assert property (p_nack_abort)
      else $error("missing acknowledge not aborted");
   property p_restart;
      ack_end && !q.flt[SY_SDA] && (q.sq == SQ_SUB) && q.rd
         |=> (q.st == ST_I_START) && (q.sq == SQ_ADDR_R);
   endproperty
   a_restart: assert property (p_restart)
      else $error("read without repeated start");
   property p_mosi_fall;
      $changed(q.mosi) && !q.cs_n |-> $fell(q.serial_port_clock);
   endproperty
   a_mosi_fall: assert property (p_mosi_fall)
      else $error("serial data changed off the falling edge");
   property p_pulse_count;
      $rose(q.cs_n) |-> rises_q == ({1'b0, q.nlen, 3'b000} + 12'h008);
   endproperty
   a_pulse_count: assert property (p_pulse_count)
      else $error("wrong clock pulse count in frame");
endmodule : dsrs_host

// ===== sim/dsrs_slave_model.sv
/*
 dsrs_slave_model: behavioural register slave on a two-wire link and
 a four/three-wire serial port, 128 byte register file.
 assumes the bench resolves the shared lines and pull-ups.
*/
module dsrs_slave_model (
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic cs_n_i,
   input  wire logic spc_i,
   input  wire logic sdi_i,
   input  wire logic sa_lsb_i,
   input  wire logic slow_i,
   output logic      scl_pd_o,
   output logic      sda_pd_o,
   output logic      sdo_o,
   output logic      sdi_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [128];
   logic [7:0] sh, rb, ss, sr;
   logic [6:0] idx;
   logic [5:0] sidx;
   logic       act, rd, inc, srd, sinc;
   int         bc, ph, sbc;
   wire        tw = mem[7'h23][0];

   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'(i << 1) ^ 8'ha4;
      {scl_pd_o, sda_pd_o, sdo_o, sdi_oe_o, act, srd} = 6'h00;
   end

   // two-wire link only while chip select idles high
   always @(negedge sda_i)
      if (scl_i && cs_n_i)
      begin
         act = 1'b1;
         rd = 1'b0;
         bc = 0;
         ph = 0;
      end

   always @(posedge sda_i)
      if (scl_i && cs_n_i)
         act = 1'b0;

   always @(posedge scl_i)
      if (act)
      begin
         if (bc < 8)
            sh = {sh[6:0], sda_i};
         else if (rd && sda_i)
            act = 1'b0;
         else if (rd && ph == 2)
            idx = idx + 7'(inc);
         bc = (bc == 8) ? 0 : bc + 1;
      end

   always @(negedge scl_i)
      if (act)
      begin
         sda_pd_o = 1'b0;
         if (bc == 8 && !rd)
         begin
            if (ph == 0 && sh[7:1] != {6'h0c, sa_lsb_i})
               act = 1'b0;
            else
            begin
               case (ph)
                  0: rd = sh[0];
                  1: {inc, idx} = sh;
                  default:
                  begin
                     mem[idx] = sh;
                     idx = idx + 7'(inc);
                  end
               endcase
               ph = (ph == 2) ? 2 : ph + 1;
               sda_pd_o = 1'b1;
               if (slow_i)
               begin
                  scl_pd_o = 1'b1;
                  scl_pd_o <= #1500 1'b0;
               end
            end
         end
         else if (rd && bc < 8)
         begin
            if (bc == 0)
            begin
               rb = mem[idx];
               ph = 2;
            end
            sda_pd_o = ~rb[7 - bc];
         end
      end

   always @(negedge cs_n_i)
      sbc = 0;

   // released output shows the inverse of its last bit
   always @(posedge cs_n_i)
   begin
      sdi_oe_o = 1'b0;
      sdo_o = ~sdo_o;
   end

   always @(posedge spc_i)
      if (!cs_n_i)
      begin
         ss = {ss[6:0], sdi_i};
         sbc = sbc + 1;
         if (sbc == 8)
            {srd, sinc, sidx} = ss;
         else if (sbc % 8 == 0)
         begin
            if (!srd)
               mem[sidx] = ss;
            sidx = sidx + 6'(sinc);
         end
      end

   always @(negedge spc_i)
      if (!cs_n_i && srd && sbc >= 8)
      begin
         if (sbc % 8 == 0)
            sr = mem[sidx];
         sdo_o = sr[7 - sbc % 8];
         sdi_oe_o = tw;
      end
endmodule : dsrs_slave_model

// ===== sim/dsrs_host_bench.sv
/*
 dsrs_host_bench: drives command bursts on both links and checks
 returned data, slave register contents and wire counts.
 assumes dsrs_slave_model as the far side; pull-ups on scl, sda and sdi.
*/
module dsrs_host_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       cmd_start_i = 1'b0;
   logic       cmd_read_i = 1'b0;
   logic       cmd_spi_i = 1'b0;
   logic       three_wire_select_i = 1'b0;
   logic       auto_increment_bit_i = 1'b0;
   logic       addr_lsb_select_pin_i = 1'b0;
   logic [6:0] cmd_reg_i = 7'h00;
   logic [7:0] cmd_len_i = 8'h01;
   logic [7:0] write_data_bits_i = 8'h00;
   logic       pin_lsb = 1'b1;
   logic       slow = 1'b0;
   logic [7:0] rdata_o;
   logic       wdata_take_o, rdata_valid_o, busy_o, done_o, nack_o;
   logic       scl_o, scl_oe_o, sda_o, sda_oe_o, cs_n_o;
   logic       serial_port_clock_o, sdi_o, sdi_oe_o;
   logic       scl_pd, sda_pd, sdo, s_oe;
   logic [7:0] shadow [128];
   int         err_count = 0;
   int         checks = 0;
   int         rises, falls;
   int         idle_bad = 0;
   int         hold_bad = 0;
   realtime    t_scl = 0.0;
   realtime    t_sda = 0.0;
   wire        scl = ~(scl_oe_o | scl_pd);
   wire        sda = ~(sda_oe_o | sda_pd);
   wire        sdi = sdi_oe_o ? sdi_o : (s_oe ? sdo : 1'b1);

   always #12.5 clk_i = ~clk_i;
   always @(posedge serial_port_clock_o)
      if (!cs_n_o)
         rises++;
   always @(negedge cs_n_o)
      falls++;
   always @(posedge clk_i)
      if (cs_n_o && !serial_port_clock_o)
         idle_bad++;
   // host data must keep clear of clock edges, the slave acts on both
   always @(scl)
   begin
      if (!srst_i && $realtime - t_sda < 100.0)
         hold_bad++;
      t_scl = $realtime;
   end
   always @(sda_oe_o)
   begin
      if (!srst_i && $realtime - t_scl < 100.0)
         hold_bad++;
      t_sda = $realtime;
   end

   dsrs_host dut (
      .clk_i(clk_i), .srst_i(srst_i), .cmd_start_i(cmd_start_i),
      .cmd_read_i(cmd_read_i), .cmd_spi_i(cmd_spi_i),
      .three_wire_select_i(three_wire_select_i),
      .auto_increment_bit_i(auto_increment_bit_i),
      .addr_lsb_select_pin_i(addr_lsb_select_pin_i),
      .cmd_reg_i(cmd_reg_i), .cmd_len_i(cmd_len_i),
      .write_data_bits_i(write_data_bits_i), .wdata_take_o(wdata_take_o),
      .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .busy_o(busy_o),
      .done_o(done_o), .nack_o(nack_o), .scl_i(scl), .scl_o(scl_o),
      .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .cs_n_o(cs_n_o),
      .serial_port_clock_o(serial_port_clock_o), .sdi_i(sdi),
      .sdi_o(sdi_o), .sdi_oe_o(sdi_oe_o), .sdo_i(sdo));

   dsrs_slave_model slave (
      .scl_i(scl), .sda_i(sda), .cs_n_i(cs_n_o),
      .spc_i(serial_port_clock_o), .sdi_i(sdi), .sa_lsb_i(pin_lsb),
      .slow_i(slow), .scl_pd_o(scl_pd), .sda_pd_o(sda_pd),
      .sdo_o(sdo), .sdi_oe_o(s_oe));

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   function automatic logic [6:0] ix(logic spi, inc, logic [6:0] rg,
                                     int k);
      if (spi)
         return {1'b0, 6'(rg[5:0] + (inc ? k : 0))};
      return 7'(rg + (inc ? k : 0));
   endfunction : ix

   // one command; ack low means the address is expected refused
   task automatic xfer(input logic spi, rd, inc, lsb, ack,
                       input logic [6:0] rg, input int n,
                       input logic [7:0] base);
      int k;
      int r;
      int t;
      k = 0;
      r = 0;
      rises = 0;
      falls = 0;
      cmd_spi_i = spi;
      cmd_read_i = rd;
      auto_increment_bit_i = inc;
      addr_lsb_select_pin_i = lsb;
      cmd_reg_i = rg;
      cmd_len_i = 8'(n);
      write_data_bits_i = base;
      cmd_start_i = 1'b1;
      @(posedge clk_i);
      #2;
      cmd_start_i = 1'b0;
      for (t = 0; t < 40000 && !done_o; t++)
      begin
         @(posedge clk_i);
         #2;
         if (wdata_take_o)
         begin
            k++;
            write_data_bits_i = base + 8'(k);
         end
         if (rdata_valid_o)
         begin
            chk("rdata", rdata_o, shadow[ix(spi, inc, rg, r)]);
            r++;
         end
      end
      if (!done_o)
      begin
         err_count++;
         close_out();
      end
      chk("nack", nack_o, !ack);
      chk("busy", busy_o, 1'b0);
      chk("cs_falls", falls, spi);
      if (spi)
         chk("spc_rises", rises, 16 + 8 * (n - 1));
      if (rd && ack)
         chk("reads", r, n);
      if (!rd && ack)
         for (int j = 0; j < n; j++)
            shadow[ix(spi, inc, rg, j)] = base + 8'(j);
      for (int j = 0; j <= n; j++)
         chk("mem", slave.mem[ix(spi, 1'b1, rg, j)],
             shadow[ix(spi, 1'b1, rg, j)]);
      chk("spc_idle", idle_bad, 0);
      chk("sda_hold", hold_bad, 0);
   endtask : xfer

   task automatic sc_reset;
      chk("cs_idle", cs_n_o, 1'b1);
      chk("scl_rel", {scl_o, sda_o, scl_oe_o, sda_oe_o, busy_o},
          5'h00);
   endtask : sc_reset

   task automatic sc_i2c_write;
      xfer(0, 0, 1, 1, 1, 7'h10, 3, 8'h31);
      xfer(0, 0, 0, 1, 1, 7'h40, 2, 8'hc0);
   endtask : sc_i2c_write

   task automatic sc_i2c_nack;
      xfer(0, 0, 1, 0, 0, 7'h20, 1, 8'h77);
   endtask : sc_i2c_nack

   task automatic sc_i2c_read;
      pin_lsb = 1'b0;
      slow = 1'b1;
      xfer(0, 1, 1, 0, 1, 7'h0f, 4, 8'h00);
      slow = 1'b0;
      xfer(0, 1, 0, 0, 1, 7'h40, 2, 8'h00);
   endtask : sc_i2c_read

   task automatic sc_spi_four;
      xfer(1, 0, 1, 0, 1, 7'h05, 2, 8'h90);
      xfer(1, 1, 1, 0, 1, 7'h04, 3, 8'h00);
      xfer(1, 1, 0, 0, 1, 7'h06, 2, 8'h00);
   endtask : sc_spi_four

   task automatic sc_spi_three;
      xfer(1, 0, 0, 0, 1, 7'h23, 1, 8'h01);
      three_wire_select_i = 1'b1;
      xfer(1, 1, 1, 0, 1, 7'h04, 3, 8'h00);
      xfer(1, 0, 1, 0, 1, 7'h30, 2, 8'h5c);
   endtask : sc_spi_three

   initial
   begin
      for (int i = 0; i < 128; i++)
         shadow[i] = 8'(i << 1) ^ 8'ha4;
      repeat (8) @(posedge clk_i);
      #2;
      srst_i = 1'b0;
      sc_reset();
      sc_i2c_write();
      sc_i2c_nack();
      sc_i2c_read();
      sc_spi_four();
      sc_spi_three();
      close_out();
   end
endmodule : dsrs_host_bench
